// File: rtl/scag_top.sv
/*
 Scanline coordinate address generator: raster display address counter
 plus two axis accumulators producing input coordinates with blanking.
 Assumes the controller drives start and step inputs synchronously to
 clk_i, updating them during horizontal blanking.
*/
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Output address runs left to right, then lines top to bottom, repeating.
// - Output address is horizontal and vertical offset from upper left corner.
// - Each pixel adds a constant step per axis; no multiplication.
// - Per-axis start value loads the accumulator for the next line.
// - Per-axis step is added every pixel clock during the active line.
// - Coordinates carry 10 integer and 4 fraction bits, 14 per axis.
// - Accumulators and steps are 16 bits; top 14 bits form the coordinate.
// - Pixels mapping outside the input image are flagged blank.
// - One coordinate pair per clock, continuously, for one channel.
// - Fraction bits go out as interpolation weights; integers address storage.
module scag_top #(
    parameter int H_ACTIVE = scag_pkg::H_ACTIVE_DEF,
    parameter int H_BLANK  = scag_pkg::H_BLANK_DEF,
    parameter int V_ACTIVE = scag_pkg::V_ACTIVE_DEF,
    parameter int IMG_W    = scag_pkg::IMG_W_DEF,
    parameter int IMG_H    = scag_pkg::IMG_H_DEF
) (
    // Clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               nrst_i,
    // Controller: per-line start points and per-pixel steps
    input  wire logic [scag_pkg::ACC_W-1:0]         x_start_i,
    input  wire logic [scag_pkg::ACC_W-1:0]         y_start_i,
    input  wire logic [scag_pkg::ACC_W-1:0]         horizontal_step_i,
    input  wire logic [scag_pkg::ACC_W-1:0]         vertical_step_i,
    // Display address
    output logic [scag_pkg::ADDR_W-1:0]             disp_x_o,
    output logic [scag_pkg::ADDR_W-1:0]             disp_y_o,
    output logic                                    active_o,
    output logic                                    line_start_o,
    output logic                                    frame_start_o,
    // Input-image coordinate
    output logic [scag_pkg::INT_W-1:0]              src_x_int_o,
    output logic [scag_pkg::INT_W-1:0]              src_y_int_o,
    output logic [2*scag_pkg::FRAC_W-1:0]           weight_idx_o,
    output logic                                    blank_o
);
    localparam int H_TOTAL = H_ACTIVE + H_BLANK;
    localparam int HC_W = $clog2(H_TOTAL + 1);
    localparam int VC_W = $clog2(V_ACTIVE + 1);
    localparam logic [HC_W-1:0] H_LAST = HC_W'(H_TOTAL - 1);
    localparam logic [HC_W-1:0] H_ACT  = HC_W'(H_ACTIVE);
    localparam logic [VC_W-1:0] V_LAST = VC_W'(V_ACTIVE - 1);
    localparam logic [HC_W-1:0] HC_ZERO = '0;
    localparam logic [VC_W-1:0] VC_ZERO = '0;
    localparam logic [scag_pkg::INT_W:0] IMG_W_L = (scag_pkg::INT_W+1)'(IMG_W);
    localparam logic [scag_pkg::INT_W:0] IMG_H_L = (scag_pkg::INT_W+1)'(IMG_H);

    scag_axis_if ax_x ();
    scag_axis_if ax_y ();

    // Raster counters
    logic [HC_W-1:0] hcnt_r;
    logic [HC_W-1:0] hcnt_nxt;
    logic [VC_W-1:0] vcnt_r;
    logic [VC_W-1:0] vcnt_nxt;

    always_comb begin
        hcnt_nxt = hcnt_r + HC_W'(1);
        vcnt_nxt = vcnt_r;
        if (hcnt_r == H_LAST) begin
            hcnt_nxt = HC_ZERO;
            vcnt_nxt = (vcnt_r == V_LAST) ? VC_ZERO : vcnt_r + VC_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hcnt_r <= HC_ZERO;
            vcnt_r <= VC_ZERO;
        end else begin
            hcnt_r <= hcnt_nxt;
            vcnt_r <= vcnt_nxt;
        end
    end

    // Load at the last blanking cycle so pixel 0 sees the line start; the
    // sampled start is whatever the controller left during blanking
    logic line_load;
    logic in_active;
    assign line_load = (hcnt_r == H_LAST);
    assign in_active = (hcnt_r < H_ACT);

    // Start and step registers follow the controller only outside the active
    // line, so every pixel of one line sees one step
    // Limitation: the first line after reset steps by zero, no blanking passed yet
    logic [scag_pkg::ACC_W-1:0] xs_r;
    logic [scag_pkg::ACC_W-1:0] xs_nxt;
    logic [scag_pkg::ACC_W-1:0] ys_r;
    logic [scag_pkg::ACC_W-1:0] ys_nxt;
    logic [scag_pkg::ACC_W-1:0] hst_r;
    logic [scag_pkg::ACC_W-1:0] hst_nxt;
    logic [scag_pkg::ACC_W-1:0] vst_r;
    logic [scag_pkg::ACC_W-1:0] vst_nxt;

    always_comb begin
        xs_nxt  = xs_r;
        ys_nxt  = ys_r;
        hst_nxt = hst_r;
        vst_nxt = vst_r;
        if (!in_active) begin
            xs_nxt  = x_start_i;
            ys_nxt  = y_start_i;
            hst_nxt = horizontal_step_i;
            vst_nxt = vertical_step_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            xs_r  <= scag_pkg::ACC_RST;
            ys_r  <= scag_pkg::ACC_RST;
            hst_r <= scag_pkg::ACC_RST;
            vst_r <= scag_pkg::ACC_RST;
        end else begin
            xs_r  <= xs_nxt;
            ys_r  <= ys_nxt;
            hst_r <= hst_nxt;
            vst_r <= vst_nxt;
        end
    end

    assign ax_x.load  = line_load;
    assign ax_x.step  = in_active;
    assign ax_x.start = xs_r;
    assign ax_x.incr  = hst_r;
    assign ax_y.load  = line_load;
    assign ax_y.step  = in_active;
    assign ax_y.start = ys_r;
    assign ax_y.incr  = vst_r;

    scag_axis_acc u_acc_x (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ax     (ax_x)
    );
    scag_axis_acc u_acc_y (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .ax     (ax_y)
    );

    // Coordinate split and range test
    logic [scag_pkg::INT_W-1:0]  x_int;
    logic [scag_pkg::INT_W-1:0]  y_int;
    logic [scag_pkg::FRAC_W-1:0] x_frac;
    logic [scag_pkg::FRAC_W-1:0] y_frac;
    logic                        outside;
    assign x_int  = ax_x.coord[scag_pkg::COORD_W-1 -: scag_pkg::INT_W];
    assign y_int  = ax_y.coord[scag_pkg::COORD_W-1 -: scag_pkg::INT_W];
    assign x_frac = ax_x.coord[scag_pkg::FRAC_W-1:0];
    assign y_frac = ax_y.coord[scag_pkg::FRAC_W-1:0];
    // Negative coordinates wrap high (512 and up), so they fail the bound test only when that image size is 512 or less
    assign outside = ({1'b0, x_int} >= IMG_W_L) || ({1'b0, y_int} >= IMG_H_L);

    // Output registers: one pair per clock, one cycle behind the accumulators
    logic [scag_pkg::ADDR_W-1:0]   dx_r;
    logic [scag_pkg::ADDR_W-1:0]   dx_nxt;
    logic [scag_pkg::ADDR_W-1:0]   dy_r;
    logic [scag_pkg::ADDR_W-1:0]   dy_nxt;
    logic                          act_r;
    logic                          act_nxt;
    logic                          ls_r;
    logic                          ls_nxt;
    logic                          fs_r;
    logic                          fs_nxt;
    logic [scag_pkg::INT_W-1:0]    sx_r;
    logic [scag_pkg::INT_W-1:0]    sx_nxt;
    logic [scag_pkg::INT_W-1:0]    sy_r;
    logic [scag_pkg::INT_W-1:0]    sy_nxt;
    logic [2*scag_pkg::FRAC_W-1:0] w_r;
    logic [2*scag_pkg::FRAC_W-1:0] w_nxt;
    logic                          blk_r;
    logic                          blk_nxt;

    always_comb begin
        act_nxt = in_active;
        dx_nxt  = in_active ? scag_pkg::ADDR_W'(hcnt_r) : dx_r;
        dy_nxt  = scag_pkg::ADDR_W'(vcnt_r);
        ls_nxt  = (hcnt_r == HC_ZERO);
        fs_nxt  = (hcnt_r == HC_ZERO) && (vcnt_r == VC_ZERO);
        sx_nxt  = x_int;
        sy_nxt  = y_int;
        w_nxt   = {y_frac, x_frac};
        blk_nxt = outside || !in_active;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dx_r  <= '0;
            dy_r  <= '0;
            act_r <= 1'b0;
            ls_r  <= 1'b0;
            fs_r  <= 1'b0;
            sx_r  <= '0;
            sy_r  <= '0;
            w_r   <= '0;
            blk_r <= 1'b1;
        end else begin
            dx_r  <= dx_nxt;
            dy_r  <= dy_nxt;
            act_r <= act_nxt;
            ls_r  <= ls_nxt;
            fs_r  <= fs_nxt;
            sx_r  <= sx_nxt;
            sy_r  <= sy_nxt;
            w_r   <= w_nxt;
            blk_r <= blk_nxt;
        end
    end

    assign disp_x_o      = dx_r;
    assign disp_y_o      = dy_r;
    assign active_o      = act_r;
    assign line_start_o  = ls_r;
    assign frame_start_o = fs_r;
    assign src_x_int_o   = sx_r;
    assign src_y_int_o   = sy_r;
    assign weight_idx_o  = w_r;
    assign blank_o       = blk_r;
endmodule
`default_nettype wire

// File: rtl/scag_pkg.sv
/*
 Shared constants for the scanline coordinate address generator.
 Assumes a single pixel clock domain; no registers reached by software.
*/
package scag_pkg;
    localparam int ACC_W   = 16;
    localparam int INT_W   = 10;
    localparam int FRAC_W  = 4;
    localparam int COORD_W = INT_W + FRAC_W;
    localparam int GUARD_W = ACC_W - COORD_W;
    localparam int ADDR_W  = 10;
    localparam int H_ACTIVE_DEF = 640;
    localparam int H_BLANK_DEF  = 160;
    localparam int V_ACTIVE_DEF = 480;
    localparam int IMG_W_DEF    = 1024;
    localparam int IMG_H_DEF    = 1024;
    localparam logic [ACC_W-1:0] ACC_RST = 16'h0000;
    localparam real  PIX_RATE_MHZ = 14.3;
    localparam real  CLK_RATE_MHZ = 25.0;
endpackage

// File: rtl/scag_axis_if.sv
/*
 Interface carrying one axis accumulator's controls and result.
 Assumes the top module drives loads and steps on the pixel clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface scag_axis_if;
    logic                             load;
    logic                             step;
    logic [scag_pkg::ACC_W-1:0]       start;
    logic [scag_pkg::ACC_W-1:0]       incr;
    logic [scag_pkg::COORD_W-1:0]     coord;
    modport ctrl (output load, output step, output start, output incr, input coord);
    modport acc  (input load, input step, input start, input incr, output coord);
endinterface
`default_nettype wire

// File: rtl/scag_axis_acc.sv
/*
 One axis accumulator: loads a line start, then adds a step each pixel.
 Assumes start and incr are stable while they are used.
*/
`timescale 1ns/1ns
`default_nettype none
module scag_axis_acc (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    // Controls and result
    scag_axis_if.acc    ax
);
    logic [scag_pkg::ACC_W-1:0] acc_r;
    logic [scag_pkg::ACC_W-1:0] acc_nxt;

    always_comb begin
        acc_nxt = acc_r;
        if (ax.load) begin
            acc_nxt = ax.start;
        end else if (ax.step) begin
            // Plain add, no multiply; wraps modulo the accumulator width
            acc_nxt = acc_r + ax.incr;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_r <= scag_pkg::ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Guard bits dropped only at the output, so step error stays small
    assign ax.coord = acc_r[scag_pkg::ACC_W-1 -: scag_pkg::COORD_W];
endmodule
`default_nettype wire

// File: dv/scag_chk.sv
/*
 Port checker for scag_top.
 Assumes it is bound from the bench top, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module scag_chk #(
    parameter int H_ACTIVE = 8,
    parameter int V_ACTIVE = 4,
    parameter int IMG_W    = 8,
    parameter int IMG_H    = 8
) (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       nrst_i,
    // Observed outputs
    input wire logic [9:0] disp_x_o,
    input wire logic [9:0] disp_y_o,
    input wire logic       active_o,
    input wire logic       line_start_o,
    input wire logic       frame_start_o,
    input wire logic [9:0] src_x_int_o,
    input wire logic [9:0] src_y_int_o,
    input wire logic       blank_o
);
    logic [9:0]  ly_r;
    logic [15:0] run_r;
    // Last line number and length of the current active run
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ly_r  <= 10'h000;
            run_r <= 16'h0000;
        end else begin
            if (line_start_o) ly_r <= disp_y_o;
            run_r <= active_o ? run_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_ls_col: assert property (line_start_o |-> active_o && disp_x_o == 10'h000)
        else $error("line start off column 0");
    a_x_step: assert property (active_o && $past(active_o) |-> disp_x_o == $past(disp_x_o) + 10'h001)
        else $error("column did not advance by one");
    a_fs_line: assert property (frame_start_o |-> line_start_o && disp_y_o == 10'h000)
        else $error("frame start off line 0");
    a_y_next: assert property (line_start_o && !frame_start_o |-> disp_y_o == ly_r + 10'h001)
        else $error("line did not advance by one");
    a_y_wrap: assert property (line_start_o && ly_r == V_ACTIVE - 1 |-> frame_start_o)
        else $error("no frame start after last line");
    a_blank_idle: assert property (!active_o |-> blank_o)
        else $error("inactive pixel not blanked");
    a_blank_out: assert property (active_o && (src_x_int_o >= IMG_W || src_y_int_o >= IMG_H) |-> blank_o)
        else $error("outside pixel not blanked");
    a_blank_in: assert property (active_o && src_x_int_o < IMG_W && src_y_int_o < IMG_H |-> !blank_o)
        else $error("inside pixel blanked");
    a_line_len: assert property ($fell(active_o) |-> run_r == H_ACTIVE)
        else $error("active run length wrong");
    c_frame: cover property (frame_start_o);
    c_out: cover property (active_o && blank_o);
    c_in: cover property (active_o && !blank_o);
endmodule
`default_nettype wire

// File: dv/scag_ctrl_model.sv
/*
 Controller model: per-line starts and steps.
 Assumes active_i is the block's active output.
*/
`timescale 1ns/1ns
`default_nettype none
module scag_ctrl_model (
    // Clock and status
    input  wire logic   clk_i,
    input  wire logic   active_i,
    // Starts and steps
    output logic [15:0] x_start_o,
    output logic [15:0] y_start_o,
    output logic [15:0] h_step_o,
    output logic [15:0] v_step_o
);
    logic was_r;
    // One process draws every value, so the seed below fixes the whole run
    initial begin
        void'($urandom(32'h82B0));
        x_start_o = 16'h0000;
        y_start_o = 16'h0000;
        h_step_o  = 16'h0050;
        v_step_o  = 16'h0010;
        was_r     = 1'b0;
        // Change only after a line ends, so the load edge sees stable values
        forever begin
            @(negedge clk_i);
            was_r <= active_i;
            if (was_r && !active_i) begin
                x_start_o <= 16'($urandom & 32'h3FF);
                y_start_o <= 16'($urandom & 32'h3FF);
                h_step_o  <= 16'($urandom & 32'h7F);
                v_step_o  <= 16'($urandom & 32'h7F);
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/test_scanline_coordinate_address_generator.sv
/*
 Bench for scag_top: predictor queues, monitor compares.
 Assumes a small raster of 8x4 active, 4 blank, 8x8 image.
*/
`timescale 1ns/1ns
`default_nettype none
module test_scanline_coordinate_address_generator;
    localparam int HA = 8, HB = 4, VA = 4, IW = 8, IH = 8;
    localparam int CYC_MAX = 2 * 10 * VA * (HA + HB) + 20;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [15:0] xs, ys, hs, vs;
    logic [15:0] ax = 16'h0000, ay = 16'h0000;
    logic [15:0] xr = 16'h0000, yr = 16'h0000, hr = 16'h0000, vr = 16'h0000;
    bit          rst_low = 1'b0;
    logic [9:0]  dx, dy, sxi, syi;
    logic [7:0]  wi;
    logic        act, ls, fs, blk;
    logic [50:0] exp_q[$];
    int          n_fail = 0, checks_done = 0, cyc = 0, col = 0, line = 0;
    task chk(input logic [50:0] seen, input logic [50:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task end_of_test;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    scag_top #(.H_ACTIVE(HA), .H_BLANK(HB), .V_ACTIVE(VA), .IMG_W(IW), .IMG_H(IH)) dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .x_start_i(xs), .y_start_i(ys),
        .horizontal_step_i(hs), .vertical_step_i(vs), .disp_x_o(dx), .disp_y_o(dy), .active_o(act),
        .line_start_o(ls), .frame_start_o(fs), .src_x_int_o(sxi), .src_y_int_o(syi),
        .weight_idx_o(wi), .blank_o(blk));
    scag_ctrl_model ctl_u (.clk_i(clk_i), .active_i(act), .x_start_o(xs), .y_start_o(ys),
        .h_step_o(hs), .v_step_o(vs));
    initial forever #20 clk_i = ~clk_i;
    // Predictor: start and step registers follow the inputs only in blanking,
    // accumulators load in the last blank cycle and step per active pixel
    always @(posedge clk_i) begin
        rst_low = !nrst_i;
        if (nrst_i) begin
            if (col < HA) begin
                exp_q.push_back({col[9:0], line[9:0], ax[15:6], ay[15:6], ay[5:2], ax[5:2],
                    ax[15:6] >= IW || ay[15:6] >= IH, col == 0, col == 0 && line == 0});
                ax = ax + hr;
                ay = ay + vr;
            end else begin
                if (col == HA + HB - 1) begin
                    ax = xr;
                    ay = yr;
                    line = (line + 1) % VA;
                end
                xr = xs;
                yr = ys;
                hr = hs;
                vr = vs;
            end
            col = (col + 1) % (HA + HB);
        end else begin
            col = 0;
            line = 0;
            ax = 16'h0000;
            ay = 16'h0000;
            xr = 16'h0000;
            yr = 16'h0000;
            hr = 16'h0000;
            vr = 16'h0000;
            exp_q.delete();
        end
    end
    always @(negedge clk_i) begin
        if (nrst_i && act) chk({dx, dy, sxi, syi, wi, blk, ls, fs}, exp_q.pop_front());
        else if (nrst_i) chk({50'h0, blk}, 51'h1);
        else if (rst_low) chk({dx, dy, sxi, syi, wi, blk, ls, fs}, {48'h0, 3'h4});
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == CYC_MAX) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        nrst_i = 1'b1;
        // Second reset lands in mid-line, after column 2
        repeat (5 * VA * (HA + HB) + 3) @(negedge clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (5 * VA * (HA + HB)) @(negedge clk_i);
        chk(51'(exp_q.size()), 51'h0);
        end_of_test();
    end
endmodule
bind scag_top scag_chk #(.H_ACTIVE(H_ACTIVE), .V_ACTIVE(V_ACTIVE), .IMG_W(IMG_W), .IMG_H(IMG_H)) chk_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .disp_x_o(disp_x_o), .disp_y_o(disp_y_o), .active_o(active_o),
    .line_start_o(line_start_o), .frame_start_o(frame_start_o), .src_x_int_o(src_x_int_o),
    .src_y_int_o(src_y_int_o), .blank_o(blank_o));
`default_nettype wire
